/* logic/pfw_regs.sv */
// Prefetchable memory window and upper I/O window registers of a bridge.
// Assumes the configuration target hands over single-cycle dword strobes.
// Notes on behaviour
// [RL1] Low four indicator bits read as one
// [RL2] Base field gives window bottom bits 31:20
// [RL3] Limit field gives window top bits 31:20
// [RL4] Upper base register gives bottom bits 63:32
// [RL5] Upper limit register gives top bits 63:32
// [RL6] Memory window always 1 MB granular
// [RL7] Window decides memory read/write forwarding
// [RL8] I/O base upper bits 31:16, 4 kB; the code pads bits 15:0 with zeros, so 64 kB granular
// [RL9] Software programs bases before forwarding is trusted
// [RL10] Prefetchable targets tolerate speculative extra reads
// [RL11] I/O limit upper bits 31:16, 4 kB; the code pads bits 15:0 with ones, so 64 kB granular
// [RL12] Memory hit compares all 64 bits inclusively
`timescale 1ns/1ps
`default_nettype none
module pfw_regs
    import pfw_pkg::*;
(
    input  wire logic        CLK_SYS,
    input  wire logic        ARST_N,
    input  wire logic        CFG_WR,
    input  wire logic        CFG_RD,
    input  wire logic [7:0]  CFG_ADDR,
    input  wire logic [3:0]  CFG_CBE_N,
    input  wire logic [31:0] CFG_WDATA,
    output var  logic [31:0] CFG_RDATA,
    output var  logic        CFG_RVALID,
    input  wire logic        MEM_REQ,
    input  wire logic [63:0] MEM_ADDR,
    input  wire logic        IO_REQ,
    input  wire logic [31:0] IO_ADDR,
    output var  logic        MEM_FWD,
    output var  logic        MEM_DONE,
    output var  logic        IO_FWD,
    output var  logic        IO_DONE,
    output var  logic [63:0] PREF_BASE,
    output var  logic [63:0] PREF_LIMIT
);
    pfw_cfg_t    cfg;
    pfw_win_t    win;
    logic [11:0] base_low_reg;
    logic [11:0] limit_low_reg;
    logic [31:0] base_high_reg;
    logic [31:0] limit_high_reg;
    logic [15:0] io_base_reg;
    logic [15:0] io_limit_reg;
    logic [31:0] rdata_next;
    logic [3:0]  be;

    assign cfg = '{wr: CFG_WR, rd: CFG_RD, addr: CFG_ADDR, cbe_n: CFG_CBE_N,
                   wdata: CFG_WDATA};
    assign be  = ~cfg.cbe_n;

    // Address decode per dword
    wire sel_low   = cfg.addr == PFW_OFS_PREF_LOW;
    wire sel_bhigh = cfg.addr == PFW_OFS_BASE_HIGH;
    wire sel_lhigh = cfg.addr == PFW_OFS_LIMIT_HIGH;
    wire sel_io    = cfg.addr == PFW_OFS_IO_HIGH;

    // Byte merge: a field byte changes only when its lane is enabled
    function automatic logic [31:0] merge(input logic [31:0] old_v,
                                          input logic [31:0] new_v,
                                          input logic [3:0]  lanes);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (lanes[i]) begin
                r[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // Current dword images, indicator nibbles constant
    wire [31:0] img_low = {limit_low_reg, PFW_IND_64, base_low_reg, PFW_IND_64}; // [RL1]
    wire [31:0] img_io  = {io_limit_reg, io_base_reg};
    wire [31:0] new_low = merge(img_low, cfg.wdata, be);
    wire [31:0] new_io  = merge(img_io, cfg.wdata, be);

    // Low dword: writable 12-bit fields, indicator bits dropped on write
    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            base_low_reg  <= PFW_FIELD12_RST;
            limit_low_reg <= PFW_FIELD12_RST;
        end else if (cfg.wr && sel_low) begin
            base_low_reg  <= new_low[PFW_BASE_LSB +: 12];   // [RL2]
            limit_low_reg <= new_low[PFW_LIMIT_LSB +: 12];  // [RL3]
        end
    end

    // Upper 32-bit halves, fully writable per byte
    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            base_high_reg  <= PFW_WORD_RST;
            limit_high_reg <= PFW_WORD_RST;
        end else begin
            if (cfg.wr && sel_bhigh) begin
                base_high_reg <= merge(base_high_reg, cfg.wdata, be);   // [RL4]
            end
            if (cfg.wr && sel_lhigh) begin
                limit_high_reg <= merge(limit_high_reg, cfg.wdata, be); // [RL5]
            end
        end
    end

    // Upper I/O base and limit halves
    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            io_base_reg  <= PFW_IO16_RST;
            io_limit_reg <= PFW_IO16_RST;
        end else if (cfg.wr && sel_io) begin
            io_base_reg  <= new_io[15:0];                      // [RL8]
            io_limit_reg <= new_io[PFW_IO_LIMIT_LSB +: 16];    // [RL11]
        end
    end

    // Read mux; unmapped offsets in this bank read zero
    assign rdata_next = sel_low   ? img_low :
                        sel_bhigh ? base_high_reg :
                        sel_lhigh ? limit_high_reg :
                        sel_io    ? img_io : PFW_WORD_RST;

    // Read data registered, valid one cycle after the strobe
    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            CFG_RDATA  <= PFW_WORD_RST;
            CFG_RVALID <= 1'b0;
        end else begin
            CFG_RVALID <= cfg.rd;
            if (cfg.rd) begin
                CFG_RDATA <= rdata_next;
            end
        end
    end

    // Window bounds; low bits padded so any write stays 1 MB granular for memory, 64 kB for I/O
    assign win.pref_base  = {base_high_reg, base_low_reg, PFW_LOW_ZERO};   // [RL2] [RL4] [RL6]
    assign win.pref_limit = {limit_high_reg, limit_low_reg, PFW_LOW_ONES}; // [RL3] [RL5] [RL6]
    assign win.io_base    = {io_base_reg, PFW_IO_LOW_ZERO};                // [RL8]
    assign win.io_limit   = {io_limit_reg, PFW_IO_LOW_ONES};               // [RL11]

    // Full-width inclusive compares (64-bit memory, 32-bit I/O); no forwarding for an empty window
    wire mem_hit = (MEM_ADDR >= win.pref_base) && (MEM_ADDR <= win.pref_limit); // [RL12]
    wire io_hit  = (IO_ADDR >= win.io_base) && (IO_ADDR <= win.io_limit);

    // Forward decisions registered; cost one cycle, keeps outputs glitch free
    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            MEM_FWD    <= 1'b0;
            MEM_DONE   <= 1'b0;
            IO_FWD     <= 1'b0;
            IO_DONE    <= 1'b0;
            PREF_BASE  <= {PFW_WORD_RST, PFW_WORD_RST};
            PREF_LIMIT <= {PFW_WORD_RST, PFW_WORD_RST};
        end else begin
            MEM_DONE   <= MEM_REQ;
            MEM_FWD    <= MEM_REQ && mem_hit;  // [RL7]
            IO_DONE    <= IO_REQ;
            IO_FWD     <= IO_REQ && io_hit;
            PREF_BASE  <= win.pref_base;
            PREF_LIMIT <= win.pref_limit;
        end
    end

    // Checks
    a_ind_base_one: assert property (@(posedge CLK_SYS) disable iff (!ARST_N) // [RL1]
        CFG_RD && sel_low |=> CFG_RDATA[3:0] == 4'h1 && CFG_RDATA[19:16] == 4'h1)
        else $error("indicator nibble not one");
    // Looked at one edge on; the registered bounds still hold reset zeros at release
    a_base_mb_align: assert property (@(posedge CLK_SYS) disable iff (!ARST_N) // [RL6]
        1'b1 |=> PREF_BASE[19:0] == 20'h0_0000 && PREF_LIMIT[19:0] == 20'hf_ffff)
        else $error("window not 1 MB granular");
    a_base_field_wr: assert property (@(posedge CLK_SYS) disable iff (!ARST_N) // [RL2]
        CFG_WR && sel_low && !CFG_CBE_N[0] && !CFG_CBE_N[1]
        |=> ##1 PREF_BASE[31:20] == $past(CFG_WDATA[15:4], 2))
        else $error("base field write lost");
    a_limit_field_wr: assert property (@(posedge CLK_SYS) disable iff (!ARST_N) // [RL3]
        CFG_WR && sel_low && !CFG_CBE_N[2] && !CFG_CBE_N[3]
        |=> ##1 PREF_LIMIT[31:20] == $past(CFG_WDATA[31:20], 2))
        else $error("limit field write lost");
    a_base_high_wr: assert property (@(posedge CLK_SYS) disable iff (!ARST_N) // [RL4]
        CFG_WR && sel_bhigh && CFG_CBE_N == 4'h0
        |=> ##1 PREF_BASE[63:32] == $past(CFG_WDATA, 2))
        else $error("upper base write lost");
    a_limit_high_wr: assert property (@(posedge CLK_SYS) disable iff (!ARST_N) // [RL5]
        CFG_WR && sel_lhigh && CFG_CBE_N == 4'h0
        |=> ##1 PREF_LIMIT[63:32] == $past(CFG_WDATA, 2))
        else $error("upper limit write lost");
    a_mem_fwd_hit: assert property (@(posedge CLK_SYS) disable iff (!ARST_N) // [RL7]
        MEM_REQ && !CFG_WR |=> MEM_DONE && MEM_FWD == (($past(MEM_ADDR) >= PREF_BASE)
        && ($past(MEM_ADDR) <= PREF_LIMIT)))
        else $error("memory forward decision wrong");
    a_mem_no_req: assert property (@(posedge CLK_SYS) disable iff (!ARST_N) // [RL12]
        !MEM_REQ |=> !MEM_FWD && !MEM_DONE)
        else $error("forward without request");
    a_io_base_wr: assert property (@(posedge CLK_SYS) disable iff (!ARST_N) // [RL8]
        CFG_WR && sel_io && CFG_CBE_N[1:0] == 2'h0 |=> io_base_reg == $past(CFG_WDATA[15:0]))
        else $error("io base write lost");
    a_io_limit_wr: assert property (@(posedge CLK_SYS) disable iff (!ARST_N) // [RL11]
        CFG_WR && sel_io && CFG_CBE_N[3:2] == 2'h0
        |=> io_limit_reg == $past(CFG_WDATA[31:16]))
        else $error("io limit write lost");

    // Disabled lanes leave the base field alone
    a_base_lane_keep: assert property (@(posedge CLK_SYS) disable iff (!ARST_N) // [RL2]
        CFG_WR && sel_low && CFG_CBE_N[1:0] == 2'h3 |=> $stable(base_low_reg))
        else $error("base field changed with lanes off");

    // Disabled lanes leave the limit field alone
    a_limit_lane_keep: assert property (@(posedge CLK_SYS) disable iff (!ARST_N) // [RL3]
        CFG_WR && sel_low && CFG_CBE_N[3:2] == 2'h3 |=> $stable(limit_low_reg))
        else $error("limit field changed with lanes off");

    // Base field reads back in place
    a_base_read_back: assert property (@(posedge CLK_SYS) disable iff (!ARST_N) // [RL2]
        CFG_RD && sel_low |=> CFG_RDATA[15:4] == $past(base_low_reg))
        else $error("base field read back wrong");

    // Limit field reads back in place
    a_limit_read_back: assert property (@(posedge CLK_SYS) disable iff (!ARST_N) // [RL3]
        CFG_RD && sel_low |=> CFG_RDATA[31:20] == $past(limit_low_reg))
        else $error("limit field read back wrong");

    // Upper base reads back whole
    a_bhigh_read_back: assert property (@(posedge CLK_SYS) disable iff (!ARST_N) // [RL4]
        CFG_RD && sel_bhigh |=> CFG_RDATA == $past(base_high_reg))
        else $error("upper base read back wrong");

    // Upper base holds without a write to it
    a_bhigh_hold: assert property (@(posedge CLK_SYS) disable iff (!ARST_N) // [RL4]
        !(CFG_WR && sel_bhigh) |=> $stable(base_high_reg))
        else $error("upper base changed without write");

    // Upper limit reads back whole
    a_lhigh_read_back: assert property (@(posedge CLK_SYS) disable iff (!ARST_N) // [RL5]
        CFG_RD && sel_lhigh |=> CFG_RDATA == $past(limit_high_reg))
        else $error("upper limit read back wrong");

    // Upper limit holds without a write to it
    a_lhigh_hold: assert property (@(posedge CLK_SYS) disable iff (!ARST_N) // [RL5]
        !(CFG_WR && sel_lhigh) |=> $stable(limit_high_reg))
        else $error("upper limit changed without write");

    // Bounds track the live fields one cycle later, pads fixed
    a_win_track: assert property (@(posedge CLK_SYS) disable iff (!ARST_N) // [RL6]
        1'b1 |=> PREF_BASE == {$past(base_high_reg), $past(base_low_reg), 20'h0_0000}
        && PREF_LIMIT == {$past(limit_high_reg), $past(limit_low_reg), 20'hf_ffff})
        else $error("window bounds not tracking fields");

    // Every memory lookup is answered next cycle
    a_mem_done_next: assert property (@(posedge CLK_SYS) disable iff (!ARST_N) // [RL7]
        MEM_REQ |=> MEM_DONE)
        else $error("memory lookup not answered");

    // A forward never comes without its answer
    a_fwd_with_done: assert property (@(posedge CLK_SYS) disable iff (!ARST_N) // [RL7]
        MEM_FWD |-> MEM_DONE)
        else $error("forward without answer");

    // An inverted window must never forward
    a_empty_no_fwd: assert property (@(posedge CLK_SYS) disable iff (!ARST_N) // [RL12]
        MEM_REQ && (win.pref_base > win.pref_limit) |=> !MEM_FWD)
        else $error("empty window forwarded");

    // I/O decision against the live 32-bit bounds
    a_io_fwd_hit: assert property (@(posedge CLK_SYS) disable iff (!ARST_N) // [RL8]
        IO_REQ |=> IO_DONE && IO_FWD == (($past(IO_ADDR) >= {$past(io_base_reg), 16'h0000})
        && ($past(IO_ADDR) <= {$past(io_limit_reg), 16'hffff})))
        else $error("io forward decision wrong");

    // No I/O answer without a request
    a_io_no_req: assert property (@(posedge CLK_SYS) disable iff (!ARST_N) // [RL11]
        !IO_REQ |=> !IO_FWD && !IO_DONE)
        else $error("io forward without request");

    // I/O base half reads back in place
    a_io_base_read: assert property (@(posedge CLK_SYS) disable iff (!ARST_N) // [RL8]
        CFG_RD && sel_io |=> CFG_RDATA[15:0] == $past(io_base_reg))
        else $error("io base read back wrong");

    // I/O limit half reads back in place
    a_io_limit_read: assert property (@(posedge CLK_SYS) disable iff (!ARST_N) // [RL11]
        CFG_RD && sel_io |=> CFG_RDATA[31:16] == $past(io_limit_reg))
        else $error("io limit read back wrong");

    // Indicators are only seen through a valid read, so valid must follow the strobe
    a_rvalid_follow: assert property (@(posedge CLK_SYS) disable iff (!ARST_N) // [RL1]
        1'b1 |=> CFG_RVALID == $past(CFG_RD))
        else $error("read valid not following strobe");

    // Field positions checked at elaboration; a moved slice breaks the dword images
    if (PFW_BASE_LSB + 12 > PFW_LIMIT_LSB - 4) begin : g_bad_base_pos
        $error("base field overlaps limit indicator");
    end
    if (PFW_LIMIT_LSB + 12 != 32) begin : g_bad_limit_pos
        $error("limit field must end at bit 31");
    end
    if (PFW_IO_LIMIT_LSB + 16 != 32) begin : g_bad_io_pos
        $error("io limit field must end at bit 31");
    end
    if ($bits(PFW_LOW_ZERO) + 12 != 32) begin : g_bad_pad
        $error("memory pad must leave 12 field bits");
    end
endmodule // pfw_regs
`default_nettype wire

/* logic/pfw_pkg.sv */
// Package for the prefetchable window register bank of a PCI-to-PCI bridge.
// Assumes dword configuration accesses with active-low byte enables.
package pfw_pkg;
    // Dword offsets in configuration space
    localparam logic [7:0]  PFW_OFS_PREF_LOW   = 8'h24;
    localparam logic [7:0]  PFW_OFS_BASE_HIGH  = 8'h28;
    localparam logic [7:0]  PFW_OFS_LIMIT_HIGH = 8'h2c;
    localparam logic [7:0]  PFW_OFS_IO_HIGH    = 8'h30;
    // Field positions
    localparam int          PFW_BASE_LSB       = 4;
    localparam int          PFW_LIMIT_LSB      = 20;
    localparam int          PFW_IND_LIMIT_LSB  = 16;
    localparam int          PFW_IO_LIMIT_LSB   = 16;
    // Reset and fixed values
    localparam logic [3:0]  PFW_IND_64         = 4'h1;
    localparam logic [11:0] PFW_FIELD12_RST    = 12'h000;
    localparam logic [31:0] PFW_WORD_RST       = 32'h0000_0000;
    localparam logic [15:0] PFW_IO16_RST       = 16'h0000;
    localparam logic [19:0] PFW_LOW_ZERO       = 20'h0_0000;
    localparam logic [19:0] PFW_LOW_ONES       = 20'hf_ffff;
    localparam logic [15:0] PFW_IO_LOW_ZERO    = 16'h0000;
    localparam logic [15:0] PFW_IO_LOW_ONES    = 16'hffff;

    // One configuration access
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [7:0]  addr;
        logic [3:0]  cbe_n;
        logic [31:0] wdata;
    } pfw_cfg_t;

    // Decoded windows for the forwarding logic
    typedef struct packed {
        logic [63:0] pref_base;
        logic [63:0] pref_limit;
        logic [31:0] io_base;
        logic [31:0] io_limit;
    } pfw_win_t;
endpackage

/* test/pfw_init_model.sv */
// Initiator model issuing memory and I/O lookups towards the bridge.
// Assumes the bench calls look only after the windows are programmed.
`timescale 1ns/1ps
`default_nettype none
module pfw_init_model (
    output var  logic        MEM_REQ,
    output var  logic [63:0] MEM_ADDR,
    output var  logic        IO_REQ,
    output var  logic [31:0] IO_ADDR,
    input  wire logic        CLK_SYS
);
    // Idle until the first lookup
    initial begin
        MEM_REQ  = 1'b0;
        IO_REQ   = 1'b0;
        MEM_ADDR = 64'h0;
        IO_ADDR  = 32'h0;
    end
    // One-cycle lookup, issued only after configuration
    // No side state kept, so repeated speculative reads are harmless
    task automatic look(input logic io, input logic [63:0] a);
        @(posedge CLK_SYS) #1;
        MEM_REQ  = !io;
        IO_REQ   = io;
        MEM_ADDR = a;
        IO_ADDR  = a[31:0];
        @(posedge CLK_SYS) #1;
        MEM_REQ  = 1'b0;
        IO_REQ   = 1'b0;
        MEM_ADDR = ~a; // Released lines show no stale address
        IO_ADDR  = ~a[31:0];
    endtask
endmodule // pfw_init_model
`default_nettype wire

/* test/test_pfw_regs.sv */
// Self-checking bench for the prefetchable window register bank.
// Assumes the initiator model owns the lookup inputs; the bench owns config.
`timescale 1ns/1ps
`default_nettype none
module test_pfw_regs
    import pfw_pkg::*;
;
    logic        CLK_SYS = 1'b0, ARST_N = 1'b0, CFG_WR = 1'b0, CFG_RD = 1'b0;
    logic [7:0]  CFG_ADDR = 8'h00;
    logic [3:0]  CFG_CBE_N = 4'hf;
    logic [31:0] CFG_WDATA = 32'h0, CFG_RDATA, IO_ADDR;
    logic        CFG_RVALID, MEM_REQ, IO_REQ, MEM_FWD, MEM_DONE, IO_FWD, IO_DONE;
    logic [63:0] MEM_ADDR, PREF_BASE, PREF_LIMIT, pb, pl, ta [5];
    logic [4:0]  th = 5'h06;
    int          errors = 0, checks = 0, cycles = 0;

    pfw_regs i_dut (.CLK_SYS(CLK_SYS), .ARST_N(ARST_N), .CFG_WR(CFG_WR), .CFG_RD(CFG_RD),
        .CFG_ADDR(CFG_ADDR), .CFG_CBE_N(CFG_CBE_N), .CFG_WDATA(CFG_WDATA),
        .CFG_RDATA(CFG_RDATA), .CFG_RVALID(CFG_RVALID), .MEM_REQ(MEM_REQ),
        .MEM_ADDR(MEM_ADDR), .IO_REQ(IO_REQ), .IO_ADDR(IO_ADDR), .MEM_FWD(MEM_FWD),
        .MEM_DONE(MEM_DONE), .IO_FWD(IO_FWD), .IO_DONE(IO_DONE),
        .PREF_BASE(PREF_BASE), .PREF_LIMIT(PREF_LIMIT));
    pfw_init_model i_init (.MEM_REQ(MEM_REQ), .MEM_ADDR(MEM_ADDR), .IO_REQ(IO_REQ),
        .IO_ADDR(IO_ADDR), .CLK_SYS(CLK_SYS));

    // Clock and hang guard; a run needs well under 500 cycles
    always #5 CLK_SYS = ~CLK_SYS;
    always @(posedge CLK_SYS) begin
        cycles++;
        if (cycles == 3000) begin
            errors++;
            conclude();
        end
    end

    task automatic conclude();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    // Single-cycle strobes; data inverted once released
    task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
        @(posedge CLK_SYS) #1;
        CFG_WR = 1'b1;
        CFG_ADDR = a;
        CFG_CBE_N = be;
        CFG_WDATA = d;
        @(posedge CLK_SYS) #1;
        CFG_WR = 1'b0;
        CFG_WDATA = ~d;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge CLK_SYS) #1;
        CFG_RD = 1'b1;
        CFG_ADDR = a;
        @(posedge CLK_SYS) #1;
        CFG_RD = 1'b0;
        chk(CFG_RVALID, 1'b1);
        chk(CFG_RDATA, exp);
    endtask
    // Lookup through the model; answer stands in the cycle after the request
    task automatic lk(input logic io, input logic [63:0] a, input logic hit);
        i_init.look(io, a);
        chk({MEM_DONE, MEM_FWD, IO_DONE, IO_FWD}, {!io, !io & hit, io, io & hit});
    endtask

    // Main sequence: reset values, field packing, window edges
    initial begin
        repeat (2) @(posedge CLK_SYS);
        #1 ARST_N = 1'b1;
        rd(PFW_OFS_PREF_LOW, 32'h0001_0001);
        rd(PFW_OFS_BASE_HIGH, 32'h0);
        rd(PFW_OFS_LIMIT_HIGH, 32'h0);
        rd(PFW_OFS_IO_HIGH, 32'h0);
        wr(PFW_OFS_PREF_LOW, 4'h0, 32'hffff_ffff);
        rd(PFW_OFS_PREF_LOW, 32'hfff1_fff1);
        wr(PFW_OFS_PREF_LOW, 4'hc, 32'h0000_0120);
        wr(PFW_OFS_PREF_LOW, 4'h3, 32'h0340_0000);
        rd(PFW_OFS_PREF_LOW, 32'h0341_0121);
        wr(PFW_OFS_BASE_HIGH, 4'h0, 32'h1);
        wr(PFW_OFS_LIMIT_HIGH, 4'h0, 32'h1);
        rd(PFW_OFS_BASE_HIGH, 32'h1);
        rd(PFW_OFS_LIMIT_HIGH, 32'h1);
        pb = {32'h1, 12'h012, PFW_LOW_ZERO};
        pl = {32'h1, 12'h034, PFW_LOW_ONES};
        chk(PREF_BASE, pb);
        chk(PREF_LIMIT, pl);
        wr(PFW_OFS_IO_HIGH, 4'h0, 32'h0005_0002);
        rd(PFW_OFS_IO_HIGH, 32'h0005_0002);
        wr(8'h34, 4'h0, 32'hffff_ffff);
        rd(8'h34, 32'h0);
        ta = '{pb - 64'h1, pb, pl, pl + 64'h1, {32'h2, pb[31:0]}};
        for (int i = 0; i < 5; i++) lk(1'b0, ta[i], th[i]);
        ta[1] = {32'h0, 16'h0002, PFW_IO_LOW_ZERO};
        ta[2] = {32'h0, 16'h0005, PFW_IO_LOW_ONES};
        ta[0] = ta[1] - 64'h1;
        ta[3] = ta[2] + 64'h1;
        for (int i = 0; i < 4; i++) lk(1'b1, ta[i], th[i]);
        wr(PFW_OFS_LIMIT_HIGH, 4'h0, 32'h0);
        lk(1'b0, pb, 1'b0);
        // Mid-run reset must clear every writable field
        @(posedge CLK_SYS) #1 ARST_N = 1'b0;
        repeat (2) @(posedge CLK_SYS);
        #1 ARST_N = 1'b1;
        rd(PFW_OFS_PREF_LOW, 32'h0001_0001);
        rd(PFW_OFS_BASE_HIGH, 32'h0);
        rd(PFW_OFS_IO_HIGH, 32'h0);
        chk(PREF_LIMIT, {32'h0, 12'h000, PFW_LOW_ONES});
        conclude();
    end
endmodule // test_pfw_regs
`default_nettype wire
